// ---- core/memory_boundary_scan_tap.sv ----
// Boundary-scan test access port with pin override logic
`timescale 1ns/1ps
`default_nettype none
`include "tap_consts.svh"

//Function
// - IR 8, bypass 1, ID 32, scan 135 bits
// - EXTEST captures pins, scan chain selected
// - SAMPLE/PRELOAD captures pins, scan chain selected
// - IDCODE loads ID word, ID selected
// - EXTEST and IDCODE leave memory undisturbed
// - CLAMP drives outputs from scan cells
// - CLAMP and HIGHZ select bypass bit
// - HIGHZ floats every output
// - BYPASS selects the single bypass bit
// - BYPASS leaves memory operation unaffected
// - Sample TDI rising, change TDO falling
// - Capture-IR loads 01 into IR LSBs
// - Power-up and reset preset IDCODE instruction
module memory_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int BSR_W = `TAP_BSR_W,
  // Arbitrary neutral identification value, bit 0 set
  parameter logic [`TAP_ID_W-1:0] ID_CODE = 32'h0ABC_0001
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_W-1:0] pin_in_i,
  input wire logic [BSR_W-1:0] core_out_i,
  input wire logic [BSR_W-1:0] core_oe_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [BSR_W-1:0] pin_out_o,
  output logic [BSR_W-1:0] pin_oe_o
);

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  function automatic instr_kind_t decode_instr(input logic [`TAP_IR_W-1:0] code);
    instr_kind_t k;
    k = k_bypass;
    case (code)
      `TAP_OP_EXTEST: k = k_extest;
      `TAP_OP_SAMPLE: k = k_sample;
      `TAP_OP_IDCODE: k = k_idcode;
      `TAP_OP_CLAMP: k = k_clamp;
      `TAP_OP_HIGHZ: k = k_highz;
      default: k = k_bypass;
    endcase
    return k;
  endfunction : decode_instr

  // ----------------------------------------
  // Test clock domain
  // ----------------------------------------
  tap_state_t state_reg;
  tap_state_t state_next;
  logic [`TAP_IR_W-1:0] ir_shift_reg;
  logic [`TAP_IR_W-1:0] ir_reg;
  logic [`TAP_BYP_W-1:0] byp_reg;
  logic [`TAP_ID_W-1:0] id_shift_reg;
  logic [BSR_W-1:0] bsr_reg;
  logic [BSR_W-1:0] upd_cells_reg;
  logic upd_tgl_reg;
  pin_mode_t mode_reg;
  logic [BSR_W-1:0] pin_tck;
  instr_kind_t kind;
  logic tdo_next;

  assign kind = decode_instr(ir_reg);

  // Pins are asynchronous to the test clock
  sync2 #(
    .W(BSR_W)
  ) pin_sync (
    .clk_i(tck_i),
    .nrst_i(nrst_i),
    .d_i(pin_in_i),
    .q_o(pin_tck)
  );

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_reset: state_next = tms_i ? st_reset : st_idle;
      st_idle: state_next = tms_i ? st_sel_dr : st_idle;
      st_sel_dr: state_next = tms_i ? st_sel_ir : st_cap_dr;
      st_cap_dr: state_next = tms_i ? st_exit1_dr : st_shift_dr;
      st_shift_dr: state_next = tms_i ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: state_next = tms_i ? st_upd_dr : st_pause_dr;
      st_pause_dr: state_next = tms_i ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: state_next = tms_i ? st_upd_dr : st_shift_dr;
      st_upd_dr: state_next = tms_i ? st_sel_dr : st_idle;
      st_sel_ir: state_next = tms_i ? st_reset : st_cap_ir;
      st_cap_ir: state_next = tms_i ? st_exit1_ir : st_shift_ir;
      st_shift_ir: state_next = tms_i ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: state_next = tms_i ? st_upd_ir : st_pause_ir;
      st_pause_ir: state_next = tms_i ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: state_next = tms_i ? st_upd_ir : st_shift_ir;
      st_upd_ir: state_next = tms_i ? st_sel_dr : st_idle;
    endcase
  end

  // Power-up lands in test-logic-reset
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_reg <= st_reset;
    else
      state_reg <= state_next;
  end

  // Instruction shifter and active instruction
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ir_shift_reg <= `TAP_IR_CAPTURE;
      ir_reg <= `TAP_IR_RESET;
    end
    else
    begin
      unique case (state_reg)
        st_reset: ir_reg <= `TAP_IR_RESET;
        st_cap_ir: ir_shift_reg <= `TAP_IR_CAPTURE;
        st_shift_ir: ir_shift_reg <= {tdi_i, ir_shift_reg[`TAP_IR_W-1:1]};
        st_upd_ir: ir_reg <= ir_shift_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Bypass bit
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
      byp_reg <= `TAP_BYP_CAPTURE;
    else if (state_reg == st_cap_dr)
      byp_reg <= `TAP_BYP_CAPTURE;
    else if (state_reg == st_shift_dr)
      byp_reg <= tdi_i;
  end

  // Identification shifter
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
      id_shift_reg <= '0;
    else if (state_reg == st_cap_dr && kind == k_idcode)
      id_shift_reg <= ID_CODE;
    else if (state_reg == st_shift_dr && kind == k_idcode)
      id_shift_reg <= {tdi_i, id_shift_reg[`TAP_ID_W-1:1]};
  end

  // Scan chain, MSB at TDI and LSB at TDO
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bsr_reg <= '0;
    else if (kind == k_extest || kind == k_sample)
    begin
      if (state_reg == st_cap_dr)
        bsr_reg <= pin_tck;
      else if (state_reg == st_shift_dr)
        bsr_reg <= {tdi_i, bsr_reg[BSR_W-1:1]};
    end
  end

  // Update latches change only in update-DR
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      upd_cells_reg <= '0;
      upd_tgl_reg <= 1'h0;
    end
    else if (state_reg == st_upd_dr && (kind == k_extest || kind == k_sample))
    begin
      upd_cells_reg <= bsr_reg;
      upd_tgl_reg <= ~upd_tgl_reg;
    end
  end

  // Pin override set with the instruction itself; the test clock may
  // stop right after update-IR, so no later edge can be relied on
  always_ff @(posedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mode_reg <= '0;
    else if (state_reg == st_reset)
      mode_reg <= '0;
    else if (state_reg == st_upd_ir)
    begin
      mode_reg.clamp <= (decode_instr(ir_shift_reg) == k_clamp);
      mode_reg.highz <= (decode_instr(ir_shift_reg) == k_highz);
    end
  end

  // Serial output select
  always_comb
  begin
    tdo_next = 1'h0;
    if (state_reg == st_shift_ir)
      tdo_next = ir_shift_reg[0];
    else if (state_reg == st_shift_dr)
    begin
      unique case (kind)
        k_extest: tdo_next = bsr_reg[0];
        k_sample: tdo_next = bsr_reg[0];
        k_idcode: tdo_next = id_shift_reg[0];
        k_clamp: tdo_next = byp_reg[0];
        k_highz: tdo_next = byp_reg[0];
        k_bypass: tdo_next = byp_reg[0];
      endcase
    end
  end

  // Falling edge keeps TDO stable around the far end's rising sample
  always_ff @(negedge tck_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tdo_o <= 1'h0;
      tdo_oe_o <= 1'h0;
    end
    else
    begin
      tdo_o <= tdo_next;
      tdo_oe_o <= (state_reg == st_shift_ir) || (state_reg == st_shift_dr);
    end
  end

  // ----------------------------------------
  // System clock domain
  // ----------------------------------------
  pin_mode_t mode_sys;
  logic upd_tgl_sys;
  logic upd_seen_reg;
  logic [BSR_W-1:0] cells_sys_reg;

  sync2 #(
    .W(2)
  ) mode_sync (
    .clk_i(clk_sys_i),
    .nrst_i(nrst_i),
    .d_i(mode_reg),
    .q_o(mode_sys)
  );

  sync2 #(
    .W(1)
  ) upd_sync (
    .clk_i(clk_sys_i),
    .nrst_i(nrst_i),
    .d_i(upd_tgl_reg),
    .q_o(upd_tgl_sys)
  );

  // Word is stable for a whole scan after each update; two updates
  // within three system clocks would lose the first
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      upd_seen_reg <= 1'h0;
      cells_sys_reg <= '0;
    end
    else
    begin
      upd_seen_reg <= upd_tgl_sys;
      if (upd_seen_reg != upd_tgl_sys)
        cells_sys_reg <= upd_cells_reg;
    end
  end

  // Core path untouched unless clamping or floating
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
    end
    else if (mode_sys.highz)
    begin
      pin_out_o <= core_out_i;
      pin_oe_o <= '0;
    end
    else if (mode_sys.clamp)
    begin
      pin_out_o <= cells_sys_reg;
      pin_oe_o <= '1;
    end
    else
    begin
      pin_out_o <= core_out_i;
      pin_oe_o <= core_oe_i;
    end
  end

endmodule : memory_boundary_scan_tap

`default_nettype wire

// ---- core/tap_consts.svh ----
// Constants for the boundary-scan test access port
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// ----------------------------------------
// Register lengths
// ----------------------------------------
`define TAP_IR_W 8
`define TAP_BYP_W 1
`define TAP_ID_W 32
`define TAP_BSR_W 135

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define TAP_OP_EXTEST 8'h00
`define TAP_OP_SAMPLE 8'h05
`define TAP_OP_IDCODE 8'h21
`define TAP_OP_CLAMP 8'h07
`define TAP_OP_HIGHZ 8'h03
`define TAP_OP_BYPASS 8'hFF

// ----------------------------------------
// Capture and reset values
// ----------------------------------------
`define TAP_IR_CAPTURE 8'h01
`define TAP_IR_RESET `TAP_OP_IDCODE
`define TAP_BYP_CAPTURE 1'h0

`endif

// ---- core/tap_pkg.sv ----
// Types shared by the boundary-scan test access port
`include "tap_consts.svh"

package tap_pkg;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    st_reset = 4'hF,
    st_idle = 4'hC,
    st_sel_dr = 4'h7,
    st_cap_dr = 4'h6,
    st_shift_dr = 4'h2,
    st_exit1_dr = 4'h1,
    st_pause_dr = 4'h3,
    st_exit2_dr = 4'h0,
    st_upd_dr = 4'h5,
    st_sel_ir = 4'h4,
    st_cap_ir = 4'hE,
    st_shift_ir = 4'hA,
    st_exit1_ir = 4'h9,
    st_pause_ir = 4'hB,
    st_exit2_ir = 4'h8,
    st_upd_ir = 4'hD
  } tap_state_t;

  // ----------------------------------------
  // Decoded instruction
  // ----------------------------------------
  typedef enum logic [2:0] {
    k_extest = 3'h0,
    k_sample = 3'h1,
    k_idcode = 3'h2,
    k_clamp = 3'h3,
    k_highz = 3'h4,
    k_bypass = 3'h5
  } instr_kind_t;

  // ----------------------------------------
  // Pin override mode, crosses to system clock
  // ----------------------------------------
  typedef struct packed {
    logic clamp;
    logic highz;
  } pin_mode_t;

endpackage : tap_pkg

// ---- core/sync2.sv ----
// Two-stage synchroniser for levels
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule : sync2

`default_nettype wire

// ---- test/memory_boundary_scan_tap_checker.sv ----
// Checker for the test access port
`timescale 1ns/1ps
`default_nettype none
module memory_boundary_scan_tap_checker #(
  parameter int BSR_W = 135,
  parameter logic [31:0] ID_CODE = 32'h0ABC_0001
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic [BSR_W-1:0] core_out_i,
  input wire logic [BSR_W-1:0] core_oe_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [BSR_W-1:0] pin_out_o,
  input wire logic [BSR_W-1:0] pin_oe_o
);
  // Five TMS-high edges pin the state, so no state copy is kept
  sequence ir_entry_s;
    tms_i [*5] ##1 !tms_i ##1 tms_i [*2] ##1 !tms_i [*2];
  endsequence
  reset_quiet_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tms_i [*5] |=> !tdo_oe_o) else $error("tdo driven after port reset");
  ir_capture_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    ir_entry_s |=> tdo_oe_o && tdo_o) else $error("capture-ir bit0 wrong");
  ir_upper_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    ir_entry_s ##1 !tms_i |=> !tdo_o) else $error("capture-ir bit1 wrong");
  id_first_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tms_i [*5] ##1 !tms_i ##1 tms_i ##1 !tms_i [*2] |=> tdo_oe_o && tdo_o == ID_CODE[0])
    else $error("id bit0 wrong after reset");
  shift_stay_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tdo_oe_o && !tms_i |=> tdo_oe_o) else $error("shift left with tms low");
  shift_exit_a: assert property (@(posedge tck_i) disable iff (!nrst_i)
    tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("tdo kept after shift");
  // One clock late: pins are registered on the system clock
  pin_oe_path_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(nrst_i) |-> pin_oe_o == $past(core_oe_i) || &pin_oe_o || pin_oe_o == '0)
    else $error("pin enable source wrong");
  pin_out_path_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $past(nrst_i) && |pin_oe_o && !(&pin_oe_o) |-> pin_out_o == $past(core_out_i))
    else $error("pin value not from core");
  clamp_c: cover property (@(posedge clk_sys_i) &pin_oe_o);
  highz_c: cover property (@(posedge clk_sys_i) nrst_i && pin_oe_o == '0);
  shift_c: cover property (@(posedge tck_i) tdo_oe_o && tms_i);
endmodule : memory_boundary_scan_tap_checker
bind memory_boundary_scan_tap memory_boundary_scan_tap_checker
  #(.BSR_W(BSR_W), .ID_CODE(ID_CODE))
  chk_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck_i), .tms_i(tms_i),
  .core_out_i(core_out_i), .core_oe_i(core_oe_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ---- test/jtag_host_model.sv ----
// Behavioural JTAG controller driving the test port
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input wire logic tdo_i
);
  // Test clock stands low between frames
  initial
  begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end
  // Drive in the low phase, read TDO at the rising edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #6 tck_o = 1'h1;
    tdo = tdo_i;
    #6 tck_o = 1'h0;
  endtask : step
  task automatic tap_reset;
    logic x;
    repeat (5) step(1'h1, 1'h0, x);
    step(1'h0, 1'h0, x);
  endtask : tap_reset
  // Shift n bits, then update and park in idle
  task automatic shift(input int n, input logic [142:0] din, output logic [142:0] dout);
    logic x;
    dout = '0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'h1, 1'h0, x);
    step(1'h0, 1'h0, x);
  endtask : shift
  task automatic scan_dr(input int n, input logic [142:0] din, output logic [142:0] dout);
    logic x;
    step(1'h1, 1'h0, x);
    repeat (2) step(1'h0, 1'h0, x);
    shift(n, din, dout);
  endtask : scan_dr
  task automatic load_ir(input logic [7:0] code, output logic [142:0] dout);
    logic x;
    repeat (2) step(1'h1, 1'h0, x);
    repeat (2) step(1'h0, 1'h0, x);
    shift(8, {135'h0, code}, dout);
  endtask : load_ir
endmodule : jtag_host_model
`default_nettype wire

// ---- test/memory_boundary_scan_tap_tb_top.sv ----
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module memory_boundary_scan_tap_tb_top;
  localparam logic [31:0] ID = 32'h0ABC_0001; // Arbitrary value
  localparam logic [134:0] PINS = {5{27'h6B1_2C3D}};
  localparam logic [134:0] CV = {5{27'h155_AA33}};
  logic clk_sys, nrst, tck, tms, tdi, tdo, tdo_oe;
  logic [134:0] core_out, core_oe, pin_out, pin_oe, pins;
  logic [142:0] d;
  int n_errors = 0;
  int n_tests = 0;
  always #50 clk_sys = ~clk_sys;
  jtag_host_model jtag_host_model_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  memory_boundary_scan_tap #(.ID_CODE(ID)) memory_boundary_scan_tap_i (.clk_sys_i(clk_sys),
    .nrst_i(nrst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .pin_in_i(pins),
    .core_out_i(core_out), .core_oe_i(core_oe), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  // Mode crosses a synchroniser, so allow a margin of system clocks
  task automatic settle;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic core_chk;
    settle();
    `CHK(pin_out, core_out)
    `CHK(pin_oe, core_oe)
  endtask : core_chk
  task automatic byp_chk;
    jtag_host_model_i.scan_dr(3, 143'h3, d);
    `CHK(d[2:0], 3'h6)
  endtask : byp_chk
  task automatic t_id;
    jtag_host_model_i.tap_reset();
    jtag_host_model_i.load_ir(8'hFF, d);
    `CHK(d[7:0], 8'h01)
    jtag_host_model_i.tap_reset();
    jtag_host_model_i.scan_dr(33, {143{1'h1}}, d);
    `CHK(d[32:0], {1'h1, ID})
    $display("t_id done");
  endtask : t_id
  task automatic t_scan;
    jtag_host_model_i.load_ir(8'h00, d);
    jtag_host_model_i.scan_dr(135, 143'h0, d);
    `CHK(d[134:0], PINS)
    core_chk();
    @(posedge clk_sys);
    pins <= ~PINS;
    jtag_host_model_i.load_ir(8'h05, d);
    jtag_host_model_i.scan_dr(143, {CV, 8'hA5}, d);
    `CHK(d, {8'hA5, ~PINS})
    $display("t_scan done");
  endtask : t_scan
  task automatic t_clamp;
    jtag_host_model_i.load_ir(8'h07, d);
    settle();
    `CHK(pin_oe, {135{1'h1}})
    `CHK(pin_out, CV)
    byp_chk();
    $display("t_clamp done");
  endtask : t_clamp
  task automatic t_highz;
    jtag_host_model_i.load_ir(8'h03, d);
    settle();
    `CHK(pin_oe, 135'h0)
    byp_chk();
    $display("t_highz done");
  endtask : t_highz
  task automatic t_byp;
    logic [7:0] ops [2];
    ops = '{8'hFF, 8'h5A};
    foreach (ops[k])
    begin
      jtag_host_model_i.load_ir(ops[k], d);
      @(posedge clk_sys);
      core_out <= ~core_out;
      core_chk();
      byp_chk();
    end
    $display("t_byp done");
  endtask : t_byp
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk_sys = 1'h0;
    nrst = 1'h0;
    core_out = {5{27'h2D2_D2D2}};
    core_oe = {5{27'h3C3_C3C3}};
    pins = PINS;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    t_id();
    t_scan();
    t_clamp();
    t_highz();
    t_byp();
    wrap_up();
  end
  // Whole run is about ten microseconds; a hang ends here
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : memory_boundary_scan_tap_tb_top
`default_nettype wire
